/* design/tweep_top.v */
// two-wire serial eeprom slave: bus engine around the byte array
// How it works
// R1: the array holds 256 bytes in pages of sixteen.
// R2: a write carries 1 to 16 bytes into a page latch, all programmed in one cycle.
// R3: the programming cycle is timed internally and lasts 5 ms.
// R4: with write protect high, nothing is written to the array.
// R5: with write protect low, writes proceed normally.
// R6: address-select pins that float are taken as zero (pulled low outside).
// R7: three address-select pins join the slave address compare.
// R8: while reset is active the bus is ignored; release leaves the engine idle.
// R9: reset asserted at any time abandons the transfer and returns to idle.
// R10: a stop returns to idle at once and starts the programming cycle of any loaded page (here only a page loaded since the last start).
// R11: data is only ever pulled low, otherwise released.
// R12: the master drives the clock and all start and stop conditions.
// R13: the address byte is a type prefix, three select bits and a read bit.
// R14: page-write bytes advance only the low four address bits.
// R15: the address byte is not acknowledged while programming.
// R16: the address counter points past the last byte and wraps at the top.
`timescale 1ns/1ps
`default_nettype none
`include "tweep_regs.vh"
module tweep_top #(
    parameter PROG_CYCLES = `TWEEP_PROG_CYCLES
) (
    input wire mclk,
    input wire rst_b,
    input wire scl,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_b,
    input wire address_select_bit0,
    input wire address_select_bit1,
    input wire address_select_bit2,
    input wire write_protect,
    output reg prog_busy
);
    localparam S_IDLE = 3'd0;
    localparam S_DEVA = 3'd1;
    localparam S_WADR = 3'd2;
    localparam S_WDAT = 3'd3;
    localparam S_RDAT = 3'd4;
    localparam S_RACK = 3'd5;
    localparam S_IGN = 3'd6;
    reg [2:0] st_q;
    reg scl_q, sda_q;
    reg [3:0] bit_q;
    reg [7:0] sh_q;
    reg ack_q;
    reg drv_q;
    reg [7:0] ptr_q;
    reg wrote_q;
    reg ld_en;
    reg prog_start;
    wire busy;
    wire [7:0] rd_data;
    wire scl_rise = scl & ~scl_q;
    wire scl_fall = ~scl & scl_q;
    // start and stop: data edge while clock stays high [R12]
    wire start_c = scl & scl_q & sda_q & ~sda_i;
    wire stop_c = scl & scl_q & ~sda_q & sda_i;
    wire [2:0] sel = {address_select_bit2, address_select_bit1, address_select_bit0};
    tweep_mem #(
        .PROG_CYCLES(PROG_CYCLES)
    ) u_mem (
        .mclk(mclk),
        .rst_b(rst_b),
        .rd_addr(ptr_q),
        .rd_data(rd_data),
        .ld_en(ld_en),
        .ld_addr(ptr_q),
        .ld_data(sh_q),
        .prog_start(prog_start),
        .busy_q(busy)
    );
    always @*
    begin
        // [R4] [R5] protect blocks loading, the byte is still acknowledged
        ld_en = (st_q == S_WDAT) && ack_q && scl_fall && bit_q == 4'd8 && !write_protect;
        prog_start = stop_c && wrote_q;
    end
    // [R8] [R9] asynchronous reset drops everything to idle, line released
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_q <= S_IDLE;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
            ptr_q <= 8'h00;
            wrote_q <= 1'b0;
            sda_o <= 1'b1;
            sda_oe_b <= 1'b1;
            prog_busy <= 1'b0;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda_i;
            prog_busy <= busy;
            // [R11] output is only a pull-down or release
            sda_o <= 1'b0;
            sda_oe_b <= ~drv_q;
            if (stop_c)
            begin
                // [R10] back to idle; a page loaded since the last start begins programming
                st_q <= S_IDLE;
                drv_q <= 1'b0;
                wrote_q <= 1'b0;
            end
            else if (start_c)
            begin
                st_q <= S_DEVA;
                bit_q <= 4'h0;
                drv_q <= 1'b0;
                ack_q <= 1'b0;
                wrote_q <= 1'b0;
            end
            else if (st_q != S_IDLE && st_q != S_IGN)
            begin
                if (scl_rise && bit_q < 4'd8 && st_q != S_RDAT)
                begin
                    sh_q <= {sh_q[6:0], sda_q};
                    bit_q <= bit_q + 4'h1;
                end
                else if (scl_rise && st_q == S_RDAT)
                    bit_q <= bit_q + 4'h1;
                else if (scl_rise && st_q == S_RACK && bit_q == 4'd8)
                begin
                    // master ack continues sequential read, nack ends it
                    ack_q <= ~sda_q;
                    bit_q <= 4'd9;
                end
                else if (scl_fall)
                begin
                    case (st_q)
                    S_DEVA:
                    begin
                        if (bit_q == 4'd8 && !ack_q)
                        begin
                            // [R13] [R7] [R6] [R15] match prefix and pins, silent when busy
                            if (sh_q[7:4] == `TWEEP_DEV_TYPE && sh_q[3:1] == sel && !busy)
                            begin
                                ack_q <= 1'b1;
                                drv_q <= 1'b1;
                            end
                            else
                            begin
                                st_q <= S_IGN;
                            end
                        end
                        else if (ack_q)
                        begin
                            ack_q <= 1'b0;
                            bit_q <= 4'h0;
                            if (sh_q[0])
                            begin
                                st_q <= S_RDAT;
                                sh_q <= rd_data;
                                drv_q <= ~rd_data[7];
                                ptr_q <= ptr_q + 8'h01;
                            end
                            else
                            begin
                                st_q <= S_WADR;
                                drv_q <= 1'b0;
                            end
                        end
                    end
                    S_WADR, S_WDAT:
                    begin
                        if (bit_q == 4'd8 && !ack_q)
                        begin
                            ack_q <= 1'b1;
                            drv_q <= 1'b1;
                        end
                        else if (ack_q)
                        begin
                            ack_q <= 1'b0;
                            bit_q <= 4'h0;
                            drv_q <= 1'b0;
                            if (st_q == S_WADR)
                            begin
                                ptr_q <= sh_q;
                                st_q <= S_WDAT;
                            end
                            else
                            begin
                                // [R14] [R2] wrap inside the page
                                ptr_q <= {ptr_q[7:4], ptr_q[3:0] + 4'h1};
                                wrote_q <= wrote_q | ~write_protect;
                            end
                        end
                    end
                    S_RDAT:
                    begin
                        if (bit_q == 4'd8)
                        begin
                            st_q <= S_RACK;
                            drv_q <= 1'b0;
                        end
                        else
                        begin
                            sh_q <= {sh_q[6:0], 1'b1};
                            drv_q <= ~sh_q[6];
                        end
                    end
                    S_RACK:
                    begin
                        if (bit_q == 4'd9 && ack_q)
                        begin
                            // [R16] next byte from the counter, full-array wrap
                            st_q <= S_RDAT;
                            ack_q <= 1'b0;
                            bit_q <= 4'h0;
                            sh_q <= rd_data;
                            drv_q <= ~rd_data[7];
                            ptr_q <= ptr_q + 8'h01;
                        end
                        else if (bit_q == 4'd9)
                        begin
                            st_q <= S_IGN;
                        end
                    end
                    default:
                    begin
                        st_q <= S_IGN;
                    end
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

/* design/tweep_regs.vh */
// constants for the two-wire serial eeprom slave
`ifndef TWEEP_REGS_VH
`define TWEEP_REGS_VH
// device-type prefix of the slave address; the value is arbitrary
`define TWEEP_DEV_TYPE 4'h5
`define TWEEP_MEM_AW 8
`define TWEEP_PAGE_AW 4
`define TWEEP_PAGE_BYTES 16
`define TWEEP_PROG_MS 5
`define TWEEP_CLK_KHZ 50000
`define TWEEP_PROG_CYCLES (`TWEEP_PROG_MS * `TWEEP_CLK_KHZ)
`endif

/* design/tweep_mem.v */
// byte array with page latch, programmed as one self-timed cycle
`timescale 1ns/1ps
`default_nettype none
`include "tweep_regs.vh"
module tweep_mem #(
    parameter AW = `TWEEP_MEM_AW,
    parameter PW = `TWEEP_PAGE_AW,
    parameter PROG_CYCLES = `TWEEP_PROG_CYCLES
) (
    input wire mclk,
    input wire rst_b,
    input wire [AW-1:0] rd_addr,
    output wire [7:0] rd_data,
    input wire ld_en,
    input wire [AW-1:0] ld_addr,
    input wire [7:0] ld_data,
    input wire prog_start,
    output reg busy_q
);
    localparam N = 1 << AW;
    localparam P = 1 << PW;
    reg [7:0] mem [0:N-1]; // [R1]
    reg [7:0] page_q [0:P-1];
    reg [P-1:0] dirty_q;
    reg [AW-PW-1:0] row_q;
    reg [31:0] cnt_q;
    integer k;
    assign rd_data = mem[rd_addr];
    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busy_q <= 1'b0;
            cnt_q <= 32'h0;
            dirty_q <= {P{1'b0}};
            row_q <= {(AW-PW){1'b0}};
        end
        else if (busy_q)
        begin
            // [R3] self-timed; finishes exactly at the budgeted count
            if (cnt_q == PROG_CYCLES - 1)
            begin
                busy_q <= 1'b0;
                dirty_q <= {P{1'b0}};
            end
            cnt_q <= cnt_q + 32'h1;
        end
        else if (prog_start && dirty_q != {P{1'b0}})
        begin
            busy_q <= 1'b1;
            cnt_q <= 32'h0;
        end
        else if (ld_en)
        begin
            dirty_q[ld_addr[PW-1:0]] <= 1'b1;
            row_q <= ld_addr[AW-1:PW];
        end
    end
    genvar i;
    generate
        for (i = 0; i < P; i = i + 1)
        begin : g_pg
            always @(posedge mclk)
            begin
                if (ld_en && !busy_q && ld_addr[PW-1:0] == i)
                    page_q[i] <= ld_data;
            end
        end
    endgenerate
    // one writer for the array keeps it single-driven across the page entries
    always @(posedge mclk)
    begin
        // [R2] only latched bytes are written; partial pages keep the rest
        for (k = 0; k < P; k = k + 1)
        begin
            if (busy_q && cnt_q == PROG_CYCLES - 1 && dirty_q[k])
                mem[{row_q, k[PW-1:0]}] <= page_q[k];
        end
    end
endmodule
`default_nettype wire

/* sim/tweep_master.sv */
// two-wire bus master model for the eeprom slave
`timescale 1ns/1ps
`default_nettype none
module tweep_master (
    input wire logic mclk,
    input wire logic sda_i,
    output logic scl,
    output logic sda_low
);
    initial {scl, sda_low} = 2'b10;
    // five edges a phase stays above the three that the slave needs
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // start when stp is low, stop when high
    task automatic cond(input logic stp);
        sda_low = stp;
        tick(5);
        scl = 1'b1;
        tick(5);
        sda_low = !stp;
        tick(5);
        scl = stp;
    endtask
    task automatic byt(input logic [7:0] d, input logic nine, output logic [7:0] q,
        output logic ack);
        logic [8:0] r;
        for (int i = 8; i >= 0; i--)
        begin
            sda_low = !(i ? d[i - 1] : nine);
            tick(5);
            scl = 1'b1;
            tick(3);
            r[i] = sda_i;
            tick(2);
            scl = 1'b0;
        end
        q = r[8:1];
        ack = !r[0];
    endtask
endmodule
`default_nettype wire

/* sim/tweep_top_sva.sv */
// port assertions for the eeprom slave
`timescale 1ns/1ps
`default_nettype none
module tweep_top_sva #(
    parameter PROG_CYCLES = 50
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_b,
    input wire logic write_protect,
    input wire logic prog_busy
);
    int cnt_q;
    always @(posedge mclk or negedge rst_b)
        if (!rst_b)
            cnt_q <= 0;
        else
            cnt_q <= prog_busy ? cnt_q + 1 : 0;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_rel; $rose(rst_b) |-> sda_oe_b && sda_o && !prog_busy; endproperty
    a_rel: assert property (p_rel) else $error("active at release");
    property p_low; !sda_oe_b |-> !sda_o; endproperty
    a_low: assert property (p_low) else $error("drives high");
    // the slave may only move the line while the clock is low
    property p_edge; $changed(sda_oe_b) |-> !scl && !$past(scl); endproperty
    a_edge: assert property (p_edge) else $error("moved in high phase");
    property p_hold; $fell(sda_oe_b) |=> !sda_oe_b [*4]; endproperty
    a_hold: assert property (p_hold) else $error("drive too short");
    property p_len; $fell(prog_busy) |-> cnt_q == PROG_CYCLES; endproperty
    a_len: assert property (p_len) else $error("program length");
    property p_deaf; prog_busy |-> sda_oe_b; endproperty
    a_deaf: assert property (p_deaf) else $error("answered while busy");
    property p_wp; $rose(prog_busy) |-> !write_protect; endproperty
    a_wp: assert property (p_wp) else $error("programmed when protected");
    property p_stop; scl && $rose(sda_i) |=> sda_oe_b [*3]; endproperty
    a_stop: assert property (p_stop) else $error("drive after stop");
endmodule
bind tweep_top tweep_top_sva #(.PROG_CYCLES(PROG_CYCLES)) tweep_top_sva_i (.mclk, .rst_b,
    .scl, .sda_i, .sda_o, .sda_oe_b, .write_protect, .prog_busy);
`default_nettype wire

/* sim/tweep_bench.sv */
// self-checking bench for the eeprom slave
`timescale 1ns/1ps
`default_nettype none
`include "tweep_regs.vh"
module tweep_bench;
    localparam int PROG = 400;
    logic mclk, rst_b, wp, busy, sda_o, sda_oe_b, scl, m_low, ack;
    logic [2:0] sel, dev;
    logic [7:0] q, ptr;
    logic [7:0] mem [256];
    logic [31:0] rnd = 32'h6c53dd48;
    int error_cnt = 0, comparisons = 0;
    // a released line floats to the pull-up
    wire logic sda = (sda_oe_b | sda_o) & !m_low;
    tweep_top #(.PROG_CYCLES(PROG)) tweep_top_i (.mclk(mclk), .rst_b(rst_b), .scl(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_b(sda_oe_b), .address_select_bit0(sel[0]),
        .address_select_bit1(sel[1]), .address_select_bit2(sel[2]), .write_protect(wp),
        .prog_busy(busy));
    tweep_master tweep_master_i (.mclk(mclk), .sda_i(sda), .scl(scl), .sda_low(m_low));
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = !mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic addr(input logic rd);
        tweep_master_i.cond(1'b0);
        tweep_master_i.byt({`TWEEP_DEV_TYPE, dev, rd}, 1'b1, q, ack);
    endtask
    task automatic seek(input logic [7:0] a);
        addr(1'b0);
        chk(ack === 1'b1, "address nack");
        tweep_master_i.byt(a, 1'b1, q, ack);
        ptr = a;
    endtask
    task automatic cur(input int n);
        addr(1'b1);
        chk(ack === 1'b1, "read address nack");
        for (int i = 1; i <= n; i++)
        begin
            tweep_master_i.byt(8'hff, i == n, q, ack);
            chk(!$isunknown(q) && q === mem[ptr], "read data");
            ptr++;
        end
        tweep_master_i.cond(1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input int n);
        seek(a);
        for (int i = 0; i < n; i++)
        begin
            rnd = lfsr(rnd);
            tweep_master_i.byt(rnd[7:0], 1'b1, q, ack);
            chk(ack === 1'b1, "data nack");
            if (!wp)
                mem[{a[7:4], a[3:0] + i[3:0]}] = rnd[7:0];
        end
        tweep_master_i.cond(1'b1);
        repeat (8) @(posedge mclk);
        #1;
        chk(busy === !wp, "program start");
        if (!wp)
        begin
            addr(1'b0);
            chk(ack === 1'b0, "acked while busy");
            tweep_master_i.cond(1'b1);
            for (int k = 0; k < PROG && busy !== 1'b0; k++)
                @(posedge mclk);
            #1;
            chk(busy === 1'b0, "program too long");
        end
    endtask
    task automatic rd(input logic [7:0] a, input int n);
        seek(a);
        cur(n);
    endtask
    initial
    begin
        {rst_b, wp} = 2'b00;
        sel = rnd[2:0];
        dev = sel;
        repeat (4) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        wr(8'hfe, 2);
        wr(8'h00, 1);
        rd(8'hfe, 2);
        cur(1);
        wr(8'h3e, 17);
        rd(8'h30, 16);
        wp = 1'b1;
        wr(8'h35, 3);
        wp = 1'b0;
        rd(8'h30, 16);
        dev = ~sel;
        addr(1'b0);
        chk(ack === 1'b0, "foreign address acked");
        // the remaining traffic runs with the select pins inverted
        sel = ~sel;
        dev = sel;
        // reset lands just as the slave starts sending a byte
        addr(1'b1);
        rst_b = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk(sda_oe_b === 1'b1, "drive kept in reset");
        addr(1'b0);
        chk(ack === 1'b0, "acked in reset");
        rst_b = 1'b1;
        rd(8'h30, 4);
        summarize();
    end
    initial
    begin
        #1000000;
        error_cnt++;
        $display("mismatch at %0t: watchdog", $time);
        summarize();
    end
endmodule
`default_nettype wire
